// ### bench/eip_core_model.sv
`default_nettype none
module eip_core_model (
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_auto,
  input  wire logic i_req,
  output logic      o_ack,
  output logic      o_reti
);
  logic [2:0] busy_q;
  logic       take;
  assign take = i_auto && i_req && !o_ack && busy_q == 3'h0;
  // one service, return before next take
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      o_reti <= 1'b0;
      busy_q <= 3'h0;
    end else begin
      o_ack <= take;
      o_reti <= busy_q == 3'h1;
      if (take) begin
        busy_q <= 3'h4;
      end else if (busy_q != 3'h0) begin
        busy_q <= busy_q - 3'h1;
      end
    end
  end
endmodule // eip_core_model
`default_nettype wire

// ### bench/eip_ext_irq_chk.sv
`default_nettype none
module eip_ext_irq_chk (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic [10:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_cpu_irq_req,
  input wire logic [3:0]  o_cpu_irq_src,
  input wire logic [1:0]  o_cpu_irq_level,
  input wire logic        i_cpu_irq_ack,
  input wire logic        i_cpu_stopped,
  input wire logic        o_cpu_wake,
  input wire logic        o_irq
);
  logic [7:0] en0_q, pl_q, ph_q, plp_q, php_q;
  logic       wok;
  assign wok = i_avs_write && !o_avs_waitrequest;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      en0_q <= 8'h00;
      pl_q <= 8'h00;
      ph_q <= 8'h00;
      plp_q <= 8'h00;
      php_q <= 8'h00;
    end else begin
      plp_q <= pl_q;
      php_q <= ph_q;
      if (wok && i_avs_address == {eip_pkg::REG_ENABLE0, 2'b00}) en0_q <= i_avs_writedata[7:0];
      if (wok && i_avs_address == {eip_pkg::REG_PRIO_LOW, 2'b00}) pl_q <= i_avs_writedata[7:0];
      if (wok && i_avs_address == {eip_pkg::REG_PRIO_HIGH, 2'b00}) ph_q <= i_avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_rdata_hi: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_ack_drop: assert property (i_cpu_irq_ack && o_cpu_irq_req |=> !o_cpu_irq_req)
    else $error("request stays after ack");
  chk_src_range: assert property (o_cpu_irq_req |-> o_cpu_irq_src <= 4'ha)
    else $error("source index out of range");
  chk_rst_idle: assert property ($past(i_sys_rst) |-> !o_cpu_irq_req && !o_irq)
    else $error("outputs active after reset");
  chk_wake_stop: assert property (o_cpu_wake |-> i_cpu_stopped)
    else $error("wake while running");
  chk_global_off: assert property (!en0_q[7] && !$past(en0_q[7]) |-> !o_cpu_irq_req)
    else $error("request while globally disabled");
  chk_level_map: assert property (o_cpu_irq_req |->
    o_cpu_irq_level == {php_q[o_cpu_irq_src[3:1]], plp_q[o_cpu_irq_src[3:1]]})
    else $error("level does not match group priority");
  cover property (i_cpu_irq_ack && o_cpu_irq_req);
  cover property (o_cpu_wake);
  cover property (o_irq);
endmodule // eip_ext_irq_chk
bind eip_ext_irq_ctl eip_ext_irq_chk i_chk (.i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_cpu_irq_req, .o_cpu_irq_src, .o_cpu_irq_level,
  .i_cpu_irq_ack, .i_cpu_stopped, .o_cpu_wake, .o_irq);
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, rd_s = 0, wr_s = 0, wreq, pa = 1, pb = 1, stopped = 0;
  logic [10:0] adr = 11'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] user_io_pins = 8'hff;
  logic [13:0] evt = 14'h0;
  logic [3:0] treq = 4'h0, ten = 4'h0, src;
  logic [1:0] lvl;
  logic req, ack, reti, wake, irq, auto = 0;
  int failures = 0, samples_checked = 0;
  localparam int OFS[3] = '{0, 8, 11};
  initial forever #5 mclk = ~mclk;
  eip_ext_irq_ctl i_dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_avs_address(adr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_user_io_pins(user_io_pins), .i_dedicated_irq_pin_a(pa), .i_dedicated_irq_pin_b(pb), .i_smartcard_evt(evt[7:0]),
    .i_usb_rtc_keypad_evt(evt[10:8]), .i_i2c_vdd_comp_evt(evt[13:11]), .i_timer0_req(treq[0]),
    .i_timer1_req(treq[1]), .i_serial0_req(treq[2]), .i_serial1_req(treq[3]), .i_timer0_en(ten[0]),
    .i_timer1_en(ten[1]), .i_serial0_en(ten[2]), .i_serial1_en(ten[3]), .o_cpu_irq_req(req),
    .o_cpu_irq_src(src), .o_cpu_irq_level(lvl), .i_cpu_irq_ack(ack), .i_cpu_reti(reti),
    .i_cpu_stopped(stopped), .o_cpu_wake(wake), .o_irq(irq));
  eip_core_model i_core (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_auto(auto), .i_req(req), .o_ack(ack),
    .o_reti(reti));
  ////////////////////////////////////////
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [8:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= {idx, 2'b00};
    wdat <= {24'h0, wd};
    wr_s <= we;
    rd_s <= !we;
    do begin @(posedge mclk); n++; end while (wreq !== 1'b0 && n < 20);
    q = rdat[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (n >= 20) failures++;
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask
  task automatic rd(input logic [8:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic drain();
    wr(eip_pkg::REG_ENABLE0, 8'h81);
    @(posedge mclk) auto <= 1'b1;
    tick(40);
    auto <= 1'b0;
    wr(eip_pkg::REG_ENABLE0, 8'h00);
  endtask
  ////////////////////////////////////////
  task automatic s_regs();
    logic [8:0] ri [5];
    logic [7:0] rx [5];
    ri = '{eip_pkg::REG_REQ_FLAGS, eip_pkg::REG_EDGE_CTL, eip_pkg::REG_PRIO_LOW, eip_pkg::REG_PRIO_HIGH, 9'h1ff};
    rx = '{8'h00, 8'h60, 8'h7f, 8'h3f, 8'h00};
    for (int i = 0; i < 5; i++) rd(ri[i], 8'h00);
    for (int i = 1; i < 5; i++) begin
      wr(ri[i], 8'hff);
      rd(ri[i], rx[i]);
      wr(ri[i], 8'h00);
    end
  endtask
  task automatic s_prio();
    wr(eip_pkg::REG_ENABLE1, 8'h06);
    @(posedge mclk) pa <= 1'b0;
    pb <= 1'b0;
    treq[0] <= 1'b1;
    ten[0] <= 1'b1;
    tick(6);
    rd(eip_pkg::REG_REQ_FLAGS, 8'h06);
    chk({7'h0, req}, 8'h00);
    wr(eip_pkg::REG_ENABLE0, 8'h80);
    tick(3);
    @(negedge mclk) chk({4'h0, src}, 8'h02);
    @(posedge mclk) treq[0] <= 1'b0;
    tick(3);
    @(negedge mclk) chk({4'h0, src}, 8'h03);
    wr(eip_pkg::REG_PRIO_HIGH, 8'h04);
    tick(3);
    @(negedge mclk) chk({2'h0, lvl, src}, 8'h25);
    wr(eip_pkg::REG_PRIO_HIGH, 8'h00);
    drain();
    rd(eip_pkg::REG_REQ_FLAGS, 8'h00);
  endtask
  task automatic s_rise();
    wr(eip_pkg::REG_EDGE_CTL, 8'h20);
    @(posedge mclk) pa <= 1'b1;
    pb <= 1'b1;
    tick(6);
    rd(eip_pkg::REG_REQ_FLAGS, 8'h02);
    wr(eip_pkg::REG_EDGE_CTL, 8'h40);
    @(posedge mclk) pb <= 1'b0;
    tick(6);
    pb <= 1'b1;
    tick(6);
    rd(eip_pkg::REG_REQ_FLAGS, 8'h06);
    drain();
  endtask
  task automatic s_lines();
    for (int j = 0; j < 3; j++) begin
      wr(9'(eip_pkg::REG_SRC4_MASK + j), 8'h01);
      wr(eip_pkg::REG_ENABLE1, 8'(8'h08 << j));
      @(posedge mclk) evt[OFS[j]] <= 1'b1;
      tick(3);
      evt <= 14'h0;
      tick(4);
      rd(eip_pkg::REG_REQ_FLAGS, 8'(8'h08 << j));
      rd(9'(eip_pkg::REG_SRC4_FLAG + j), 8'h01);
      rd(9'(eip_pkg::REG_SRC4_FLAG + j), 8'h00);
      drain();
      rd(eip_pkg::REG_REQ_FLAGS, 8'h00);
    end
  endtask
  task automatic s_wake();
    wr(eip_pkg::REG_USR_EN, 8'h01);
    wr(eip_pkg::REG_USR_ROUTE, 8'h01);
    wr(eip_pkg::REG_TRIG_CTL, 8'h01);
    wr(eip_pkg::REG_ENABLE0, 8'h01);
    @(posedge mclk) stopped <= 1'b1;
    user_io_pins[0] <= 1'b0;
    tick(6);
    @(negedge mclk) chk({7'h0, wake}, 8'h01);
    rd(eip_pkg::REG_TRIG_CTL, 8'h03);
    @(posedge mclk) stopped <= 1'b0;
    user_io_pins <= 8'hff;
    drain();
    rd(eip_pkg::REG_TRIG_CTL, 8'h01);
  endtask
  task automatic s_evt();
    wr(eip_pkg::REG_EVT_STAT, 8'h7f);
    wr(eip_pkg::REG_EDGE_CTL, 8'h00);
    @(posedge mclk) pb <= 1'b0;
    tick(6);
    rd(eip_pkg::REG_EVT_STAT, 8'h08);
    @(negedge mclk) chk({7'h0, irq}, 8'h00);
    wr(eip_pkg::REG_EVT_MASK, 8'h08);
    @(negedge mclk) chk({7'h0, irq}, 8'h01);
    wr(eip_pkg::REG_EVT_STAT, 8'h08);
    @(negedge mclk) chk({7'h0, irq}, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    tick(2);
    sys_rst <= 1'b0;
    s_regs();
    s_prio();
    s_rise();
    s_lines();
    s_wake();
    s_evt();
    end_sim();
  end
  initial begin
    tick(20000);
    failures++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire

// ### inc/eip_pkg.sv
// Function
// R01: bit 6 of the edge control register picks the active edge of interrupt 3.
// R02: bit 5 of the edge control register picks the active edge of interrupt 2.
// R03: request flags of interrupts 2 to 6 sit in request register bits 1 to 5.
// R04: multi-source lines are ORed; each source has its own mask and flag bit.
// R05: user pins drive interrupt 0 (high priority group) and interrupt 1 (low).
// R06: interrupts 2 and 3 come only from dedicated pins with selectable polarity.
// R07: smart card onto 4; usb, rtc, keypad onto 5; i2c, supply fault, comparator onto 6.
// R08: sources of interrupts 4 to 6 become rising-edge events.
// R09: reading a multi-source flag register clears its flags.
// R10: interrupt reaches core only when enabled; flag cleared when core takes it.
// R11: interrupt 0 can wake the stopped cpu.
// R12: sources sit in six priority groups as a fixed table.
// R13: group level is priority high bit over low bit; 00 lowest, 11 highest.
// R14: same-level simultaneous requests follow a fixed polling order.
// R15: polling by group number first, left source before right source.
// R16: priority low register bit 6 is watchdog only, bit 7 reserved.
// R17: trigger type 1 gives falling edge flag, 0 gives low level trigger.
// R18: global enable bit 7 blocks all; enables 2 to 6 in enable register 1 bits 1-5. Bit 7 gates only core requests, not o_cpu_wake or o_irq.
// R19: only strictly higher level pre-empts a running service.
`default_nettype none
package eip_pkg;
  // register indices; byte address is four times the index
  localparam logic [8:0] REG_TRIG_CTL   = 9'h088;
  localparam logic [8:0] REG_ENABLE0    = 9'h0a8;
  localparam logic [8:0] REG_PRIO_LOW   = 9'h0a9;
  localparam logic [8:0] REG_ENABLE1    = 9'h0b8;
  localparam logic [8:0] REG_PRIO_HIGH  = 9'h0b9;
  localparam logic [8:0] REG_REQ_FLAGS  = 9'h0c0;
  localparam logic [8:0] REG_EDGE_CTL   = 9'h0c8;
  localparam logic [8:0] REG_SRC4_FLAG  = 9'h100;
  localparam logic [8:0] REG_SRC5_FLAG  = 9'h101;
  localparam logic [8:0] REG_SRC6_FLAG  = 9'h102;
  localparam logic [8:0] REG_SRC4_MASK  = 9'h104;
  localparam logic [8:0] REG_SRC5_MASK  = 9'h105;
  localparam logic [8:0] REG_SRC6_MASK  = 9'h106;
  localparam logic [8:0] REG_USR_EN     = 9'h108;
  localparam logic [8:0] REG_USR_ROUTE  = 9'h109;
  localparam logic [8:0] REG_EVT_STAT   = 9'h10c;
  localparam logic [8:0] REG_EVT_MASK   = 9'h10d;
  localparam logic [8:0] REG_CORE_STATE = 9'h10e;
  // field positions
  localparam int BIT_IRQ3_EDGE   = 6;
  localparam int BIT_IRQ2_EDGE   = 5;
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_EXT0_TYPE   = 0;
  localparam int BIT_EXT0_FLAG   = 1;
  localparam int BIT_EXT1_TYPE   = 2;
  localparam int BIT_EXT1_FLAG   = 3;
  localparam int BIT_EXT0_EN     = 0;
  localparam int BIT_EXT1_EN     = 2;
  localparam int BIT_WDOG_STATUS = 6;
  // reset values and masks
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] REQ_FLAGS_MASK = 8'h3e;
  localparam logic [7:0] EDGE_CTL_MASK  = 8'h60;
  localparam logic [7:0] PRIO_LOW_MASK  = 8'h7f;
  localparam logic [7:0] PRIO_HIGH_MASK = 8'h3f;
  localparam logic [7:0] ENABLE1_MASK   = 8'h3e;
  localparam logic [7:0] ENABLE0_MASK   = 8'h85;
  localparam logic [7:0] TRIG_CTL_MASK  = 8'h0f;
  // sources in polling order
  localparam int NUM_SRC = 11;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_SER1 = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_EXT3 = 5;
  localparam int SRC_TMR1 = 6;
  localparam int SRC_EXT4 = 7;
  localparam int SRC_SER0 = 8;
  localparam int SRC_EXT5 = 9;
  localparam int SRC_EXT6 = 10;
  // priority group of each source
  function automatic logic [2:0] src_group(input int src);
    begin
      src_group = 3'(src / 2);
    end
  endfunction
endpackage : eip_pkg
`default_nettype wire

// ### src/eip_ext_irq_ctl.sv
`default_nettype none
module eip_ext_irq_ctl (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave
  input  wire logic [10:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // pins
  input  wire logic [7:0]  i_user_io_pins,
  input  wire logic        i_dedicated_irq_pin_a,
  input  wire logic        i_dedicated_irq_pin_b,
  // on-chip peripheral sources, same clock
  input  wire logic [7:0]  i_smartcard_evt,
  input  wire logic [2:0]  i_usb_rtc_keypad_evt,
  input  wire logic [2:0]  i_i2c_vdd_comp_evt,
  // core-owned request levels
  input  wire logic        i_timer0_req,
  input  wire logic        i_timer1_req,
  input  wire logic        i_serial0_req,
  input  wire logic        i_serial1_req,
  input  wire logic        i_timer0_en,
  input  wire logic        i_timer1_en,
  input  wire logic        i_serial0_en,
  input  wire logic        i_serial1_en,
  // cpu handshake
  output logic             o_cpu_irq_req,
  output logic      [3:0]  o_cpu_irq_src,
  output logic      [1:0]  o_cpu_irq_level,
  input  wire logic        i_cpu_irq_ack,
  input  wire logic        i_cpu_reti,
  input  wire logic        i_cpu_stopped,
  output logic             o_cpu_wake,
  output logic             o_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state per access
  logic       ack_q;
  logic [8:0] idx;
  logic       acc_rd;
  logic       acc_wr;
  logic       mapped;
  logic [7:0] rd_val;
  logic [7:0] wbyte;
  assign idx    = i_avs_address[10:2];
  assign wbyte  = i_avs_writedata[7:0];
  assign acc_rd = i_avs_read & ack_q;
  assign acc_wr = i_avs_write & ack_q & (i_avs_address[1:0] == 2'b00);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] trig_ctl_q;
  logic [7:0] enable0_q;
  logic [7:0] enable1_q;
  logic [7:0] prio_low_q;
  logic [7:0] prio_high_q;
  logic [7:0] req_flags_q;
  logic [7:0] edge_ctl_q;
  logic [7:0] src4_flag_q;
  logic [7:0] src4_mask_q;
  logic [2:0] src5_flag_q;
  logic [2:0] src5_mask_q;
  logic [2:0] src6_flag_q;
  logic [2:0] src6_mask_q;
  logic [7:0] usr_en_q;
  logic [7:0] usr_route_q;
  logic [6:0] evt_stat_q;
  logic [6:0] evt_mask_q;
  logic [3:0] inserv_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      enable0_q   <= eip_pkg::RST_BYTE;
      enable1_q   <= eip_pkg::RST_BYTE;
      prio_low_q  <= eip_pkg::RST_BYTE;
      prio_high_q <= eip_pkg::RST_BYTE;
      edge_ctl_q  <= eip_pkg::RST_BYTE;
      src4_mask_q <= eip_pkg::RST_BYTE;
      src5_mask_q <= eip_pkg::RST_BYTE[2:0];
      src6_mask_q <= eip_pkg::RST_BYTE[2:0];
      usr_en_q    <= eip_pkg::RST_BYTE;
      usr_route_q <= eip_pkg::RST_BYTE;
      evt_mask_q  <= eip_pkg::RST_BYTE[6:0];
    end else if (acc_wr) begin
      case (idx)
        // R18 global and per-line enables
        eip_pkg::REG_ENABLE0:   enable0_q   <= wbyte & eip_pkg::ENABLE0_MASK;
        eip_pkg::REG_ENABLE1:   enable1_q   <= wbyte & eip_pkg::ENABLE1_MASK;
        // R16 watchdog bit kept, bit 7 dropped
        eip_pkg::REG_PRIO_LOW:  prio_low_q  <= wbyte & eip_pkg::PRIO_LOW_MASK;
        eip_pkg::REG_PRIO_HIGH: prio_high_q <= wbyte & eip_pkg::PRIO_HIGH_MASK;
        eip_pkg::REG_EDGE_CTL:  edge_ctl_q  <= wbyte & eip_pkg::EDGE_CTL_MASK;
        // R04 per-source masks
        eip_pkg::REG_SRC4_MASK: src4_mask_q <= wbyte;
        eip_pkg::REG_SRC5_MASK: src5_mask_q <= wbyte[2:0];
        eip_pkg::REG_SRC6_MASK: src6_mask_q <= wbyte[2:0];
        eip_pkg::REG_USR_EN:    usr_en_q    <= wbyte;
        eip_pkg::REG_USR_ROUTE: usr_route_q <= wbyte;
        eip_pkg::REG_EVT_MASK:  evt_mask_q  <= wbyte[6:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [9:0] pin_lvl;
  logic [9:0] pin_rise;
  logic [9:0] pin_fall;
  eip_sync_edge #(
    .W (10)
  ) u_pins (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_dedicated_irq_pin_b, i_dedicated_irq_pin_a, i_user_io_pins}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // R05 user pins, active low, routed to line 0 or line 1
  logic usr_line0_low;
  logic usr_line1_low;
  logic usr0_prev_q;
  logic usr1_prev_q;
  assign usr_line0_low = |(~pin_lvl[7:0] & usr_en_q & usr_route_q);
  assign usr_line1_low = |(~pin_lvl[7:0] & usr_en_q & ~usr_route_q);

  // R07 peripheral edges
  logic [7:0] sc_prev_q;
  logic [2:0] p5_prev_q;
  logic [2:0] p6_prev_q;
  logic [2:0] grp_prev_q;
  logic [2:0] grp_req;
  logic [2:0] grp_rise;
  // R04 multi-source lines ORed
  assign grp_req[0] = |(src4_flag_q & src4_mask_q);
  assign grp_req[1] = |(src5_flag_q & src5_mask_q);
  assign grp_req[2] = |(src6_flag_q & src6_mask_q);
  // R08 lines 4 to 6 as rising edges
  assign grp_rise   = grp_req & ~grp_prev_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      usr0_prev_q <= 1'b0;
      usr1_prev_q <= 1'b0;
      sc_prev_q   <= eip_pkg::RST_BYTE;
      p5_prev_q   <= eip_pkg::RST_BYTE[2:0];
      p6_prev_q   <= eip_pkg::RST_BYTE[2:0];
      grp_prev_q  <= eip_pkg::RST_BYTE[2:0];
    end else begin
      usr0_prev_q <= usr_line0_low;
      usr1_prev_q <= usr_line1_low;
      sc_prev_q   <= i_smartcard_evt;
      p5_prev_q   <= i_usb_rtc_keypad_evt;
      p6_prev_q   <= i_i2c_vdd_comp_evt;
      grp_prev_q  <= grp_req;
    end
  end

  // R09 source flags cleared by read, set wins
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      src4_flag_q <= eip_pkg::RST_BYTE;
      src5_flag_q <= eip_pkg::RST_BYTE[2:0];
      src6_flag_q <= eip_pkg::RST_BYTE[2:0];
    end else begin
      src4_flag_q <= ((acc_rd && idx == eip_pkg::REG_SRC4_FLAG) ? (src4_flag_q & ~o_avs_readdata[7:0]) : src4_flag_q)
                     | (i_smartcard_evt & ~sc_prev_q);
      src5_flag_q <= ((acc_rd && idx == eip_pkg::REG_SRC5_FLAG) ? (src5_flag_q & ~o_avs_readdata[2:0]) : src5_flag_q)
                     | (i_usb_rtc_keypad_evt & ~p5_prev_q);
      src6_flag_q <= ((acc_rd && idx == eip_pkg::REG_SRC6_FLAG) ? (src6_flag_q & ~o_avs_readdata[2:0]) : src6_flag_q)
                     | (i_i2c_vdd_comp_evt & ~p6_prev_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external flags
  logic       take;
  logic [3:0] take_src;
  logic [6:0] ext_set;
  logic [6:0] ext_flag;
  assign take     = i_cpu_irq_ack & o_cpu_irq_req;
  assign take_src = o_cpu_irq_src;
  // R17 falling edge of user lines in edge mode
  assign ext_set[0] = usr_line0_low & ~usr0_prev_q;
  assign ext_set[1] = usr_line1_low & ~usr1_prev_q;
  // R02 R06 dedicated pin a edge select
  assign ext_set[2] = edge_ctl_q[eip_pkg::BIT_IRQ2_EDGE] ? pin_rise[8] : pin_fall[8];
  // R01 R06 dedicated pin b edge select
  assign ext_set[3] = edge_ctl_q[eip_pkg::BIT_IRQ3_EDGE] ? pin_rise[9] : pin_fall[9];
  assign ext_set[6:4] = grp_rise;
  assign ext_flag = {req_flags_q[5:1], trig_ctl_q[eip_pkg::BIT_EXT1_FLAG], trig_ctl_q[eip_pkg::BIT_EXT0_FLAG]};

  function automatic logic taken(input logic t, input logic [3:0] s, input int n);
    begin
      taken = t && (s == 4'(n));
    end
  endfunction

  // R17 trigger type and edge flags of lines 0 and 1
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      trig_ctl_q <= eip_pkg::RST_BYTE;
    end else begin
      if (acc_wr && idx == eip_pkg::REG_TRIG_CTL) begin
        trig_ctl_q <= wbyte & eip_pkg::TRIG_CTL_MASK;
      end else begin
        // R10 flag cleared when taken
        if (taken(take, take_src, eip_pkg::SRC_EXT0)) begin
          trig_ctl_q[eip_pkg::BIT_EXT0_FLAG] <= 1'b0;
        end
        if (taken(take, take_src, eip_pkg::SRC_EXT1)) begin
          trig_ctl_q[eip_pkg::BIT_EXT1_FLAG] <= 1'b0;
        end
      end
      if (!trig_ctl_q[eip_pkg::BIT_EXT0_TYPE]) begin
        trig_ctl_q[eip_pkg::BIT_EXT0_FLAG] <= usr_line0_low;
      end else if (ext_set[0]) begin
        trig_ctl_q[eip_pkg::BIT_EXT0_FLAG] <= 1'b1;
      end
      if (!trig_ctl_q[eip_pkg::BIT_EXT1_TYPE]) begin
        trig_ctl_q[eip_pkg::BIT_EXT1_FLAG] <= usr_line1_low;
      end else if (ext_set[1]) begin
        trig_ctl_q[eip_pkg::BIT_EXT1_FLAG] <= 1'b1;
      end
    end
  end

  // R03 request flags of lines 2 to 6
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      req_flags_q <= eip_pkg::RST_BYTE;
    end else begin
      for (int k = 2; k <= 6; k++) begin
        if (ext_set[k]) begin
          req_flags_q[k-1] <= 1'b1;
        end else if (acc_wr && idx == eip_pkg::REG_REQ_FLAGS) begin
          req_flags_q[k-1] <= wbyte[k-1];
        // R10 flag cleared when taken
        end else if (taken(take, take_src, (k == 2) ? eip_pkg::SRC_EXT2 : (k == 3) ? eip_pkg::SRC_EXT3 :
                           (k == 4) ? eip_pkg::SRC_EXT4 : (k == 5) ? eip_pkg::SRC_EXT5 : eip_pkg::SRC_EXT6)) begin
          req_flags_q[k-1] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // priority resolution
  logic [10:0] pend;
  logic [1:0]  best_lvl;
  logic [3:0]  best_src;
  logic        found;
  logic [1:0]  top_lvl;
  logic        busy;
  logic        gate;
  // R10 R18 enable gating
  assign gate = enable0_q[eip_pkg::BIT_GLOBAL_EN];
  always_comb begin
    pend = '0;
    pend[eip_pkg::SRC_EXT0] = ext_flag[0] & enable0_q[eip_pkg::BIT_EXT0_EN];
    pend[eip_pkg::SRC_EXT1] = ext_flag[1] & enable0_q[eip_pkg::BIT_EXT1_EN];
    pend[eip_pkg::SRC_EXT2] = ext_flag[2] & enable1_q[1];
    pend[eip_pkg::SRC_EXT3] = ext_flag[3] & enable1_q[2];
    pend[eip_pkg::SRC_EXT4] = ext_flag[4] & enable1_q[3];
    pend[eip_pkg::SRC_EXT5] = ext_flag[5] & enable1_q[4];
    pend[eip_pkg::SRC_EXT6] = ext_flag[6] & enable1_q[5];
    pend[eip_pkg::SRC_TMR0] = i_timer0_req & i_timer0_en;
    pend[eip_pkg::SRC_TMR1] = i_timer1_req & i_timer1_en;
    pend[eip_pkg::SRC_SER0] = i_serial0_req & i_serial0_en;
    pend[eip_pkg::SRC_SER1] = i_serial1_req & i_serial1_en;
    pend = gate ? pend : 11'h000;
  end

  always_comb begin
    logic [2:0] g;
    logic [1:0] l;
    found    = 1'b0;
    best_lvl = 2'b00;
    best_src = 4'h0;
    g        = 3'h0;
    l        = 2'b00;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      // R12 group table
      g = eip_pkg::src_group(i);
      // R13 level from both priority registers
      l = {prio_high_q[g], prio_low_q[g]};
      // R14 R15 lower index wins ties
      if (pend[i] && (!found || l > best_lvl)) begin
        found    = 1'b1;
        best_lvl = l;
        best_src = 4'(i);
      end
    end
  end

  always_comb begin
    top_lvl = 2'b00;
    for (int j = 0; j < 4; j++) begin
      if (inserv_q[j]) begin
        top_lvl = 2'(j);
      end
    end
  end
  assign busy = |inserv_q;

  // R19 strictly higher level pre-empts
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_cpu_irq_req   <= 1'b0;
      o_cpu_irq_src   <= 4'h0;
      o_cpu_irq_level <= 2'b00;
    end else begin
      o_cpu_irq_req   <= found && (!busy || best_lvl > top_lvl) && !take;
      o_cpu_irq_src   <= best_src;
      o_cpu_irq_level <= best_lvl;
    end
  end

  // in-service levels
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      inserv_q <= 4'h0;
    end else if (take) begin
      inserv_q[o_cpu_irq_level] <= 1'b1;
    end else if (i_cpu_reti && busy) begin
      inserv_q[top_lvl] <= 1'b0;
    end
  end

  // R11 wake from stop on line 0
  assign o_cpu_wake = i_cpu_stopped & ext_flag[0] & enable0_q[eip_pkg::BIT_EXT0_EN];

  //////////////////////////////////////////////////////////////////////////////
  // event status, write one to clear, set wins
  logic [6:0] ext_rise;
  logic [6:0] ext_flag_prev_q;
  assign ext_rise = ext_flag & ~ext_flag_prev_q;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      evt_stat_q      <= eip_pkg::RST_BYTE[6:0];
      ext_flag_prev_q <= eip_pkg::RST_BYTE[6:0];
    end else begin
      ext_flag_prev_q <= ext_flag;
      evt_stat_q      <= ((acc_wr && idx == eip_pkg::REG_EVT_STAT) ? (evt_stat_q & ~wbyte[6:0]) : evt_stat_q)
                         | ext_rise;
    end
  end
  assign o_irq = |(evt_stat_q & evt_mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    mapped = 1'b1;
    case (idx)
      eip_pkg::REG_TRIG_CTL:   rd_val = trig_ctl_q;
      eip_pkg::REG_ENABLE0:    rd_val = enable0_q;
      eip_pkg::REG_ENABLE1:    rd_val = enable1_q;
      eip_pkg::REG_PRIO_LOW:   rd_val = prio_low_q;
      eip_pkg::REG_PRIO_HIGH:  rd_val = prio_high_q;
      eip_pkg::REG_REQ_FLAGS:  rd_val = req_flags_q;
      eip_pkg::REG_EDGE_CTL:   rd_val = edge_ctl_q;
      eip_pkg::REG_SRC4_FLAG:  rd_val = src4_flag_q;
      eip_pkg::REG_SRC5_FLAG:  rd_val = {5'h00, src5_flag_q};
      eip_pkg::REG_SRC6_FLAG:  rd_val = {5'h00, src6_flag_q};
      eip_pkg::REG_SRC4_MASK:  rd_val = src4_mask_q;
      eip_pkg::REG_SRC5_MASK:  rd_val = {5'h00, src5_mask_q};
      eip_pkg::REG_SRC6_MASK:  rd_val = {5'h00, src6_mask_q};
      eip_pkg::REG_USR_EN:     rd_val = usr_en_q;
      eip_pkg::REG_USR_ROUTE:  rd_val = usr_route_q;
      eip_pkg::REG_EVT_STAT:   rd_val = {1'b0, evt_stat_q};
      eip_pkg::REG_EVT_MASK:   rd_val = {1'b0, evt_mask_q};
      eip_pkg::REG_CORE_STATE: rd_val = {1'b0, o_cpu_irq_req, o_cpu_irq_level, inserv_q};
      default: begin
        rd_val = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= {24'h000000, (mapped && i_avs_address[1:0] == 2'b00) ? rd_val : 8'h00};
    end
  end
endmodule // eip_ext_irq_ctl
`default_nettype wire

// ### src/eip_sync_edge.sv
`default_nettype none
module eip_sync_edge #(
  parameter int W = 2
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser and edge detect per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          prev_q <= 1'b1;
        end else begin
          meta_q <= i_async[gi];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign o_level[gi] = sync_q;
      assign o_rise[gi]  = sync_q & ~prev_q;
      assign o_fall[gi]  = ~sync_q & prev_q;
    end
  endgenerate
endmodule // eip_sync_edge
`default_nettype wire
